// ---- rtl/level_sensor_regs.sv ----
/*
 * holding-register bank of a radar level sensor seen by a modbus host.
 * assumes decoded requests arrive from the frame layer as one-cycle
 * handshakes and that answers are framed outside, one beat per cycle.
 */
// Operation
// - distance in centimetres at register zero
// - distance in millimetres at register one
// - level in centimetres at register two
// - level in millimetres at register three
// - status code, zero normal, fault codes otherwise
// - range setting read/write at register five
// - blanking distance read/write at register six
// - low calibration point read/write at seven
// - high calibration point read/write at eight
// - signal strength zero to 150 at nine
// - 32-bit millimetre distance, high then low
// - float metre distance, high then low
// - 32-bit millimetre level, high then low
// - float metre level, high then low
// - float temperature, high then low words
// - only read-holding and write-single functions served
// - good write echoes request; differing answer fails
`default_nettype none
module level_sensor_regs (
   input  wire logic                  clock_in,
   input  wire logic                  sys_rst_in,
   input  wire lvl_regs_pkg::meas_s   meas_in,
   input  wire logic                  req_valid_in,
   input  wire lvl_regs_pkg::req_s    req_in,
   output logic                       req_ready_out,
   output logic                       resp_valid_out,
   output lvl_regs_pkg::resp_s        resp_out,
   output lvl_regs_pkg::cfg_s         cfg_out
);
   import lvl_regs_pkg::*;

   state_e      state_r;
   meas_s       snap_r;
   cfg_s        cfg_r;
   logic [15:0] idx_r;
   logic [15:0] left_r;
   logic        ready_r;
   logic        resp_valid_r;
   resp_s       resp_r;

   logic        req_fire;
   logic        is_read;
   logic        is_write;
   logic [16:0] end_addr;
   logic        rd_bad_qty;
   logic        rd_bad_addr;
   logic        wr_target_ok;
   logic        wr_in_limit;

   function automatic logic is_setting(input logic [15:0] a);
      return (a >= A_RANGE) && (a <= A_HIGH_PT);
   endfunction

   // word seen at a register: measurements from the coherent snapshot, settings live
   function automatic logic [15:0] word_of(input logic [15:0] a,
                                           input meas_s m,
                                           input cfg_s c);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         A_DIST_CM:   w = m.dist_cm;
         A_DIST_MM:   w = m.dist_mm;
         A_LVL_CM:    w = m.lvl_cm;
         A_LVL_MM:    w = m.lvl_mm;
         A_STATUS:    w = m.status;
         A_RANGE:     w = c.range_cm;
         A_BLANK:     w = c.blank_cm;
         A_LOW_PT:    w = c.low_pt_cm;
         A_HIGH_PT:   w = c.high_pt_cm;
         A_STRENGTH:  w = (m.strength > STRENGTH_MAX) ?
                          STRENGTH_MAX : m.strength;
         A_DMM32_HI:  w = m.dist_mm32[31:16];
         A_DMM32_LO:  w = m.dist_mm32[15:0];
         A_DM_F_HI:   w = m.dist_m_f[31:16];
         A_DM_F_LO:   w = m.dist_m_f[15:0];
         A_LMM32_HI:  w = m.lvl_mm32[31:16];
         A_LMM32_LO:  w = m.lvl_mm32[15:0];
         A_LM_F_HI:   w = m.lvl_m_f[31:16];
         A_LM_F_LO:   w = m.lvl_m_f[15:0];
         A_TEMP_F_HI: w = m.temp_f[31:16];
         A_TEMP_F_LO: w = m.temp_f[15:0];
         default:     w = 16'h0000;
      endcase
      return w;
   endfunction

   assign req_fire = req_valid_in & ready_r;

   always_comb begin
      is_read      = (req_in.func == FC_READ);
      is_write     = (req_in.func == FC_WRITE);
      end_addr     = {1'b0, req_in.addr} + {1'b0, req_in.data};
      rd_bad_qty   = (req_in.data == 16'h0000) ||
                     (req_in.data > MAX_READ_QTY);
      rd_bad_addr  = (end_addr > REG_COUNT);
      wr_target_ok = is_setting(req_in.addr);
      wr_in_limit  = (req_in.data <= SETTING_LIMIT);
   end

   // read sequencing: one answer beat per cycle, host held off meanwhile
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_r <= ST_IDLE;
         idx_r   <= 16'h0000;
         left_r  <= 16'h0000;
         ready_r <= 1'b1;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (req_fire && is_read && !rd_bad_qty && !rd_bad_addr) begin
                  state_r <= ST_STREAM;
                  idx_r   <= req_in.addr;
                  left_r  <= req_in.data;
                  ready_r <= 1'b0;
               end
            end
            ST_STREAM: begin
               idx_r  <= idx_r + 16'h0001;
               left_r <= left_r - 16'h0001;
               if (left_r == 16'h0001) begin
                  state_r <= ST_IDLE;
                  ready_r <= 1'b1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               ready_r <= 1'b1;
            end
         endcase
      end
   end

   // measurements frozen at the read request so split words stay paired
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         snap_r <= '0;
      end else if (req_fire && is_read) begin
         snap_r <= meas_in;
      end
   end

   // settings written by the host
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg_r.range_cm   <= RANGE_RST;
         cfg_r.blank_cm   <= BLANK_RST;
         cfg_r.low_pt_cm  <= LOW_PT_RST;
         cfg_r.high_pt_cm <= HIGH_PT_RST;
      end else if (req_fire && is_write && wr_target_ok && wr_in_limit) begin
         case (req_in.addr)
            A_RANGE:   cfg_r.range_cm   <= req_in.data;
            A_BLANK:   cfg_r.blank_cm   <= req_in.data;
            A_LOW_PT:  cfg_r.low_pt_cm  <= req_in.data;
            A_HIGH_PT: cfg_r.high_pt_cm <= req_in.data;
            default:   cfg_r.range_cm   <= cfg_r.range_cm;
         endcase
      end
   end

   // answers: read beats, write echo, or exception
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         resp_valid_r <= 1'b0;
         resp_r       <= '0;
      end else begin
         resp_valid_r <= 1'b0;
         if (state_r == ST_STREAM) begin
            resp_valid_r <= 1'b1;
            resp_r.func  <= FC_READ;
            resp_r.addr  <= idx_r;
            resp_r.data  <= word_of(idx_r, snap_r, cfg_r);
            resp_r.last  <= (left_r == 16'h0001);
         end else if (req_fire &&
                      (!is_read || rd_bad_qty || rd_bad_addr)) begin
            resp_valid_r <= 1'b1;
            resp_r.addr  <= req_in.addr;
            resp_r.last  <= 1'b1;
            if (!is_read && !is_write) begin
               resp_r.func <= req_in.func | FC_EXC_FLAG;
               resp_r.data <= EXC_BAD_FUNC;
            end else if (is_read) begin
               resp_r.func <= FC_READ | FC_EXC_FLAG;
               resp_r.data <= rd_bad_qty ? EXC_BAD_QTY : EXC_BAD_ADDR;
            end else if (!wr_target_ok) begin
               resp_r.func <= FC_WRITE | FC_EXC_FLAG;
               resp_r.data <= EXC_BAD_ADDR;
            end else begin
               resp_r.func <= FC_WRITE;
               // over-limit value: answer the kept value, not the request
               resp_r.data <= wr_in_limit ? req_in.data :
                              word_of(req_in.addr, snap_r, cfg_r);
            end
         end
      end
   end

   assign req_ready_out  = ready_r;
   assign resp_valid_out = resp_valid_r;
   assign resp_out       = resp_r;
   assign cfg_out        = cfg_r;

   // assertions
   sequence s_good_read;
      req_fire && is_read && !rd_bad_qty && !rd_bad_addr;
   endsequence

   sequence s_first_beat;
      ##2 resp_valid_out && resp_out.func == FC_READ;
   endsequence

   property p_read_first_beat;
      @(posedge clock_in) disable iff (sys_rst_in)
      s_good_read |-> s_first_beat ##0
         (resp_out.addr == $past(req_in.addr, 2));
   endproperty
   a_read_first_beat: assert property (p_read_first_beat)
      else $error("first read beat missing or misaddressed");

   property p_write_echo;
      @(posedge clock_in) disable iff (sys_rst_in)
      (req_fire && is_write && wr_target_ok && wr_in_limit) |=>
         resp_valid_out && resp_out.func == FC_WRITE &&
         resp_out.addr == $past(req_in.addr) &&
         resp_out.data == $past(req_in.data);
   endproperty
   a_write_echo: assert property (p_write_echo)
      else $error("write was not echoed unchanged");

   property p_write_stored;
      @(posedge clock_in) disable iff (sys_rst_in)
      (req_fire && is_write && req_in.addr == A_RANGE && wr_in_limit) |=>
         cfg_out.range_cm == $past(req_in.data);
   endproperty
   a_write_stored: assert property (p_write_stored)
      else $error("range setting not stored");

   property p_ro_write_refused;
      @(posedge clock_in) disable iff (sys_rst_in)
      (req_fire && is_write && !wr_target_ok) |=>
         resp_out.func == (FC_WRITE | FC_EXC_FLAG) && $stable(cfg_out);
   endproperty
   a_ro_write_refused: assert property (p_ro_write_refused)
      else $error("write to read-only register was accepted");

   property p_bad_func;
      @(posedge clock_in) disable iff (sys_rst_in)
      (req_fire && !is_read && !is_write) |=>
         resp_valid_out && resp_out.data == EXC_BAD_FUNC &&
         resp_out.func[7];
   endproperty
   a_bad_func: assert property (p_bad_func)
      else $error("unsupported function not refused");

   property p_strength_span;
      @(posedge clock_in) disable iff (sys_rst_in)
      (resp_valid_out && resp_out.func == FC_READ &&
       resp_out.addr == A_STRENGTH) |-> resp_out.data <= STRENGTH_MAX;
   endproperty
   a_strength_span: assert property (p_strength_span)
      else $error("signal strength above its span");

   property p_cfg_quiet;
      @(posedge clock_in) disable iff (sys_rst_in)
      !(req_fire && is_write) |=> $stable(cfg_out);
   endproperty
   a_cfg_quiet: assert property (p_cfg_quiet)
      else $error("setting changed without a write");

   property p_status_word;
      @(posedge clock_in) disable iff (sys_rst_in)
      (resp_valid_out && resp_out.func == FC_READ &&
       resp_out.addr == A_STATUS) |-> resp_out.data == snap_r.status;
   endproperty
   a_status_word: assert property (p_status_word)
      else $error("status word differs from measured status");

   property p_float_hi;
      @(posedge clock_in) disable iff (sys_rst_in)
      (resp_valid_out && resp_out.func == FC_READ &&
       resp_out.addr == A_TEMP_F_HI) |-> resp_out.data == snap_r.temp_f[31:16];
   endproperty
   a_float_hi: assert property (p_float_hi)
      else $error("temperature high word wrong");

   property p_busy_while_streaming;
      @(posedge clock_in) disable iff (sys_rst_in)
      s_good_read |=> !req_ready_out;
   endproperty
   a_busy_while_streaming: assert property (p_busy_while_streaming)
      else $error("request port open during a read");

   property p_bad_qty;
      @(posedge clock_in) disable iff (sys_rst_in)
      (req_fire && is_read && rd_bad_qty) |=>
         resp_valid_out && resp_out.func == (FC_READ | FC_EXC_FLAG) &&
         resp_out.data == EXC_BAD_QTY;
   endproperty
   a_bad_qty: assert property (p_bad_qty)
      else $error("bad read count not refused");

   property p_bad_addr;
      @(posedge clock_in) disable iff (sys_rst_in)
      (req_fire && is_read && !rd_bad_qty && rd_bad_addr) |=>
         resp_valid_out && resp_out.func == (FC_READ | FC_EXC_FLAG) &&
         resp_out.data == EXC_BAD_ADDR;
   endproperty
   a_bad_addr: assert property (p_bad_addr)
      else $error("read past the map not refused");

   property p_over_limit_kept;
      @(posedge clock_in) disable iff (sys_rst_in)
      (req_fire && is_write && wr_target_ok && !wr_in_limit) |=>
         resp_valid_out && resp_out.func == FC_WRITE &&
         resp_out.data != $past(req_in.data) && $stable(cfg_out);
   endproperty
   a_over_limit_kept: assert property (p_over_limit_kept)
      else $error("over-limit write stored or echoed");

   sequence s_last_beat;
      resp_valid_out && resp_out.func == FC_READ && resp_out.last;
   endsequence

   property p_last_beat_ready;
      @(posedge clock_in) disable iff (sys_rst_in)
      s_last_beat |-> req_ready_out;
   endproperty
   a_last_beat_ready: assert property (p_last_beat_ready)
      else $error("request port still closed at the last beat");

   property p_beat_train;
      @(posedge clock_in) disable iff (sys_rst_in)
      (resp_valid_out && resp_out.func == FC_READ && !resp_out.last) |=>
         resp_valid_out && resp_out.func == FC_READ &&
         resp_out.addr == $past(resp_out.addr) + 16'h0001;
   endproperty
   a_beat_train: assert property (p_beat_train)
      else $error("read beats not on consecutive registers");

   property p_snap_held;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state_r == ST_STREAM && $past(state_r) == ST_STREAM) |->
         $stable(snap_r);
   endproperty
   a_snap_held: assert property (p_snap_held)
      else $error("snapshot moved in the middle of a read");

   property p_idle_quiet;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state_r == ST_IDLE && !req_fire) |=> !resp_valid_out;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("answer without a request");

   property p_short_read_done;
      @(posedge clock_in) disable iff (sys_rst_in)
      (s_good_read ##0 (req_in.data == 16'h0001)) |-> ##2 s_last_beat;
   endproperty
   a_short_read_done: assert property (p_short_read_done)
      else $error("single-word read not answered by one last beat");

   property p_strength_pass;
      @(posedge clock_in) disable iff (sys_rst_in)
      (resp_valid_out && resp_out.func == FC_READ &&
       resp_out.addr == A_STRENGTH && snap_r.strength <= STRENGTH_MAX) |->
         resp_out.data == snap_r.strength;
   endproperty
   a_strength_pass: assert property (p_strength_pass)
      else $error("signal strength altered within its span");
endmodule
`default_nettype wire

// ---- rtl/lvl_regs_pkg.sv ----
/*
 * constants, codes and carriers of the level sensor holding-register bank.
 * assumes a modbus frame layer outside that checks address and crc and
 * hands over one decoded request (function, register, value or count).
 */
`default_nettype none
package lvl_regs_pkg;
   // register map, one 16-bit word per holding register
   localparam logic [15:0] A_DIST_CM     = 16'h0000;
   localparam logic [15:0] A_DIST_MM     = 16'h0001;
   localparam logic [15:0] A_LVL_CM      = 16'h0002;
   localparam logic [15:0] A_LVL_MM      = 16'h0003;
   localparam logic [15:0] A_STATUS      = 16'h0004;
   localparam logic [15:0] A_RANGE       = 16'h0005;
   localparam logic [15:0] A_BLANK       = 16'h0006;
   localparam logic [15:0] A_LOW_PT      = 16'h0007;
   localparam logic [15:0] A_HIGH_PT     = 16'h0008;
   localparam logic [15:0] A_STRENGTH    = 16'h0009;
   localparam logic [15:0] A_DMM32_HI    = 16'h000a;
   localparam logic [15:0] A_DMM32_LO    = 16'h000b;
   localparam logic [15:0] A_DM_F_HI     = 16'h000c;
   localparam logic [15:0] A_DM_F_LO     = 16'h000d;
   localparam logic [15:0] A_LMM32_HI    = 16'h000e;
   localparam logic [15:0] A_LMM32_LO    = 16'h000f;
   localparam logic [15:0] A_LM_F_HI     = 16'h0010;
   localparam logic [15:0] A_LM_F_LO     = 16'h0011;
   localparam logic [15:0] A_TEMP_F_HI   = 16'h0012;
   localparam logic [15:0] A_TEMP_F_LO   = 16'h0013;
   localparam logic [16:0] REG_COUNT     = 17'h00014;
   // host function codes and exception answers
   localparam logic [7:0]  FC_READ       = 8'h03;
   localparam logic [7:0]  FC_WRITE      = 8'h06;
   localparam logic [7:0]  FC_EXC_FLAG   = 8'h80;
   localparam logic [15:0] EXC_BAD_FUNC  = 16'h0001;
   localparam logic [15:0] EXC_BAD_ADDR  = 16'h0002;
   localparam logic [15:0] EXC_BAD_QTY   = 16'h0003;
   localparam logic [15:0] MAX_READ_QTY  = 16'h007d;
   // measurement status codes
   localparam logic [15:0] ST_NORMAL              = 16'h0000;
   localparam logic [15:0] ST_DISPLAY_LINK        = 16'h0001;
   localparam logic [15:0] ST_NV_WRITE            = 16'h0002;
   localparam logic [15:0] ST_SYNTH               = 16'h0003;
   localparam logic [15:0] ST_OVERLOAD            = 16'h0007;
   localparam logic [15:0] ST_SUPPLY_UNDERVOLTAGE = 16'h0008;
   localparam logic [15:0] ST_NO_VALID_ECHO       = 16'h000e;
   localparam logic [15:0] STRENGTH_MAX  = 16'h0096;
   // settings after reset and the largest value a write may store
   localparam logic [15:0] RANGE_RST     = 16'h03e8;
   localparam logic [15:0] BLANK_RST     = 16'h000a;
   localparam logic [15:0] LOW_PT_RST    = 16'h03e8;
   localparam logic [15:0] HIGH_PT_RST   = 16'h03d4;
   localparam logic [15:0] SETTING_LIMIT = 16'h2710;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_STREAM = 2'b10
   } state_e;

   typedef struct packed {
      logic [15:0] dist_cm;
      logic [15:0] dist_mm;
      logic [15:0] lvl_cm;
      logic [15:0] lvl_mm;
      logic [15:0] status;
      logic [15:0] strength;
      logic [31:0] dist_mm32;
      logic [31:0] dist_m_f;
      logic [31:0] lvl_mm32;
      logic [31:0] lvl_m_f;
      logic [31:0] temp_f;
   } meas_s;

   typedef struct packed {
      logic [15:0] range_cm;
      logic [15:0] blank_cm;
      logic [15:0] low_pt_cm;
      logic [15:0] high_pt_cm;
   } cfg_s;

   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] addr;
      logic [15:0] data;
   } req_s;

   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] addr;
      logic [15:0] data;
      logic        last;
   } resp_s;
endpackage
`default_nettype wire

// ---- tb/lvl_host_model.sv ----
/*
 * host model: issues decoded read/write requests, collects answer beats.
 * assumes the bank's request handshake and one-cycle answer beats.
 */
`default_nettype none
module lvl_host_model (
   input  wire logic                clock_in,
   input  wire logic                req_ready_in,
   input  wire logic                resp_valid_in,
   input  wire lvl_regs_pkg::resp_s resp_in,
   output var  logic                req_valid_out,
   output var  lvl_regs_pkg::req_s  req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import lvl_regs_pkg::*;
   resp_s q [$];

   initial begin
      req_valid_out = 1'b0;
      req_out = '0;
   end

   // beats are taken mid-cycle, where they have settled
   always @(negedge clock_in) begin
      if (resp_valid_in === 1'b1) begin
         q.push_back(resp_in);
      end
   end

   // holds the request up to its taking edge, then waits for n beats
   task automatic send(input req_s r, input int n);
      int k;
      q.delete();
      @(negedge clock_in);
      req_valid_out = 1'b1;
      req_out = r;
      k = 0;
      while (req_ready_in !== 1'b1 && k < 100) begin
         @(negedge clock_in);
         k++;
      end
      @(posedge clock_in);
      @(negedge clock_in);
      req_valid_out = 1'b0;
      req_out = ~r;
      k = 0;
      while (q.size() < n && k < 100) begin
         @(negedge clock_in);
         k++;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/level_sensor_regs_tb_top.sv ----
/*
 * self-checking bench of the level sensor holding-register bank.
 * assumes the host model drives the request side at falling edges.
 */
`default_nettype none
module level_sensor_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lvl_regs_pkg::*;
   logic  clock_in = 1'b0;
   logic  sys_rst_in = 1'b1;
   meas_s meas;
   cfg_s  cfg_exp;
   cfg_s  cfg;
   logic  req_valid;
   logic  req_ready;
   logic  resp_valid;
   req_s  req;
   resp_s resp;
   int    n_mismatch = 0;
   int    total_checks = 0;
   int    busy_cnt = 0;

   always #12.5 clock_in = ~clock_in;

   // cycles the request port spends closed, seen at falling edges
   always @(negedge clock_in) begin
      if (req_ready === 1'b0) begin
         busy_cnt++;
      end
   end

   level_sensor_regs uut (
      .clock_in       (clock_in),
      .sys_rst_in     (sys_rst_in),
      .meas_in        (meas),
      .req_valid_in   (req_valid),
      .req_in         (req),
      .req_ready_out  (req_ready),
      .resp_valid_out (resp_valid),
      .resp_out       (resp),
      .cfg_out        (cfg)
   );

   lvl_host_model hm (
      .clock_in      (clock_in),
      .req_ready_in  (req_ready),
      .resp_valid_in (resp_valid),
      .resp_in       (resp),
      .req_valid_out (req_valid),
      .req_out       (req)
   );

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // expected read beat: measurements, clamped strength, live settings
   function automatic logic [40:0] beat(input int a, input logic lst);
      logic [319:0] flat;
      logic [15:0]  st;
      st = (meas.strength > STRENGTH_MAX) ? STRENGTH_MAX : meas.strength;
      flat = {meas.dist_cm, meas.dist_mm, meas.lvl_cm, meas.lvl_mm,
              meas.status, cfg_exp, st, meas.dist_mm32, meas.dist_m_f,
              meas.lvl_mm32, meas.lvl_m_f, meas.temp_f};
      return {FC_READ, 16'(a), flat[319 - 16 * a -: 16], lst};
   endfunction

   task automatic t_read_all;
      int b;
      b = busy_cnt;
      hm.send({FC_READ, A_DIST_CM, 16'h0014}, 20);
      chk(hm.q.size(), 20);
      chk(busy_cnt - b, 20);
      for (int i = 0; i < 10; i++) begin
         chk(hm.q[i], beat(i, 1'b0));
      end
      for (int i = 10; i < 20; i++) begin
         chk(hm.q[i], beat(i, i == 19));
         chk(hm.q[i], beat(i, i == 19));
      end
   endtask

   task automatic t_status;
      logic [15:0] codes [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
                                 16'h0007, 16'h0008, 16'h000e};
      foreach (codes[i]) begin
         @(negedge clock_in);
         meas.status = codes[i];
         hm.send({FC_READ, A_STATUS, 16'h0001}, 1);
         chk(hm.q[0], beat(4, 1'b1));
      end
   endtask

   task automatic t_write;
      logic [15:0] v;
      for (int a = 5; a < 9; a++) begin
         v = 16'h0100 + 16'(a);
         hm.send({FC_WRITE, 16'(a), v}, 1);
         cfg_exp[16 * (8 - a) +: 16] = v;
         chk(hm.q[0], {FC_WRITE, 16'(a), v, 1'b1});
         chk(cfg, cfg_exp);
      end
      hm.send({FC_WRITE, A_BLANK, 16'h2711}, 1);
      chk(hm.q[0], {FC_WRITE, A_BLANK, 16'h0106, 1'b1});
      hm.send({FC_WRITE, A_LOW_PT, SETTING_LIMIT}, 1);
      cfg_exp.low_pt_cm = SETTING_LIMIT;
      chk(hm.q[0], {FC_WRITE, A_LOW_PT, SETTING_LIMIT, 1'b1});
      hm.send({FC_READ, A_RANGE, 16'h0004}, 4);
      for (int i = 0; i < 4; i++) begin
         chk(hm.q[i], beat(5 + i, i == 3));
      end
   endtask

   task automatic t_refuse;
      logic [39:0] rq [8] = '{40'h04_0000_0001, 40'h10_0005_0001,
                              40'h03_0000_0000, 40'h03_0000_007e,
                              40'h03_0013_0002, 40'h06_0000_1234,
                              40'h06_0009_0001, 40'h06_0014_0001};
      logic [23:0] rs [8] = '{24'h84_0001, 24'h90_0001, 24'h83_0003,
                              24'h83_0003, 24'h83_0002, 24'h86_0002,
                              24'h86_0002, 24'h86_0002};
      int b;
      b = busy_cnt;
      foreach (rq[i]) begin
         hm.send(rq[i], 1);
         chk({hm.q[0].func, hm.q[0].data}, rs[i]);
      end
      chk(cfg, cfg_exp);
      hm.send({FC_READ, A_DIST_CM, 16'h0001}, 1);
      chk(hm.q[0], beat(0, 1'b1));
      chk(busy_cnt - b, 1);
   endtask

   // settings fall back to their reset values on a reset in mid-run
   task automatic t_reset;
      hm.send({FC_WRITE, A_RANGE, 16'h0222}, 1);
      cfg_exp.range_cm = 16'h0222;
      chk(cfg, cfg_exp);
      sys_rst_in = 1'b1;
      repeat (2) @(negedge clock_in);
      cfg_exp = '{RANGE_RST, BLANK_RST, LOW_PT_RST, HIGH_PT_RST};
      chk(cfg, cfg_exp);
      chk({req_ready, resp_valid}, 2'b10);
      sys_rst_in = 1'b0;
      meas.strength = STRENGTH_MAX;
      hm.send({FC_READ, A_RANGE, 16'h0005}, 5);
      for (int i = 0; i < 5; i++) begin
         chk(hm.q[i], beat(5 + i, i == 4));
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      meas = '{16'h0064, 16'h03e8, 16'h0384, 16'h2328, 16'h0000, 16'h00c8,
               32'h000103e8, 32'h3f800000, 32'h00012328, 32'h41100000,
               32'h41c80000};
      cfg_exp = '{RANGE_RST, BLANK_RST, LOW_PT_RST, HIGH_PT_RST};
      repeat (12) @(negedge clock_in);
      sys_rst_in = 1'b0;
      chk(cfg, cfg_exp);
      chk({req_ready, resp_valid}, 2'b10);
      t_read_all();
      t_status();
      t_write();
      t_refuse();
      t_reset();
      give_verdict();
   end

   initial begin
      #(25 * 4000);
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire
